// *** rtl/pr_regs.svh ***
// Constants for the peripheral pin router: encodings, reset values, key bytes
`ifndef PR_REGS_SVH
`define PR_REGS_SVH
`define PR_SEL_W 5
`define PR_SEL_PORT_MSB 4
`define PR_SEL_PORT_LSB 3
`define PR_SEL_PIN_MSB 2
`define PR_SEL_PIN_LSB 0
`define PR_KEY_FIRST 8'h55
`define PR_KEY_SECOND 8'hAA
`define PR_LOCK_BIT 0
`define PR_OUT_SEL_RST 5'h00
`define PR_OUT_CODE_TX 5'h09
`define PR_IN_CODE_RC7 5'h17
`define PR_IN_SEL_RST_DEF 5'h00
`endif

// *** rtl/pr_pkg.sv ***
// Types shared by the peripheral pin router
package pr_pkg;
  typedef logic [4:0] pr_sel_type;
  typedef enum logic [1:0] {PR_KEY_IDLE, PR_KEY_GOT55, PR_KEY_ARMED} pr_key_type;
endpackage

// *** rtl/pr_lock_if.sv ***
// Interface carrying lock-register traffic between router and its lock unit
`timescale 1ns/1ns
interface pr_lock_if;
  logic wr;
  logic bit_op;
  logic bit_val;
  logic [7:0] data;
  logic locked;
  modport ctl (input wr, input bit_op, input bit_val, input data, output locked);
  modport top (output wr, output bit_op, output bit_val, output data, input locked);
endinterface

// *** rtl/pr_lock.sv ***
// Lock flag, key sequence and one-way lock unit
`timescale 1ns/1ns
`include "pr_regs.svh"
module pr_lock (
  input wire logic clk_in,
  input wire logic por_b_in,
  input wire logic ce_in,
  input wire logic one_way_in,
  pr_lock_if.ctl lk
);
  pr_pkg::pr_key_type key_ff;
  pr_pkg::pr_key_type nxt_key;
  logic locked_ff;
  logic nxt_locked;
  logic cleared_once_ff;
  logic set_once_ff;
  // ------------------------------------------------------------
  // Key sequence decode
  // ------------------------------------------------------------
  wire armed = (key_ff == pr_pkg::PR_KEY_ARMED);
  wire bit_hit = lk.wr && lk.bit_op && armed;
  wire may_clear = !one_way_in || !cleared_once_ff;
  wire may_set = !one_way_in || !set_once_ff;
  wire do_set = bit_hit && lk.bit_val && may_set;
  wire do_clear = bit_hit && !lk.bit_val && may_clear;
  // sequence; any other write restarts it
  always_comb begin
    nxt_key = key_ff;
    if (lk.wr) begin
      if (!lk.bit_op && lk.data == `PR_KEY_FIRST) begin
        nxt_key = pr_pkg::PR_KEY_GOT55;
      end else if (!lk.bit_op && lk.data == `PR_KEY_SECOND && key_ff == pr_pkg::PR_KEY_GOT55) begin
        nxt_key = pr_pkg::PR_KEY_ARMED;
      end else begin
        nxt_key = pr_pkg::PR_KEY_IDLE;
      end
    end
  end
  // only a bit modify changes the flag
  assign nxt_locked = do_set ? 1'b1 : (do_clear ? 1'b0 : locked_ff);
  // ------------------------------------------------------------
  // State, reset only by power-on
  // ------------------------------------------------------------
  // power-on clears one-way history
  always_ff @(posedge clk_in or negedge por_b_in) begin
    if (!por_b_in) begin
      key_ff <= pr_pkg::PR_KEY_IDLE;
      locked_ff <= 1'b0;
      cleared_once_ff <= 1'b0;
      set_once_ff <= 1'b0;
    end else if (ce_in) begin
      key_ff <= nxt_key;
      locked_ff <= nxt_locked;
      cleared_once_ff <= cleared_once_ff | do_clear;
      set_once_ff <= set_once_ff | do_set;
    end
  end
  assign lk.locked = locked_ff;
endmodule

// *** rtl/pr_router.sv ***
// Peripheral pin router: input and output selectors, pin muxing, lock
`timescale 1ns/1ns
`include "pr_regs.svh"
module pr_router #(
  parameter int N_IN = 8,
  parameter int N_OUT = 8,
  parameter int N_PIN = 32,
  parameter logic [N_IN*5-1:0] IN_RST = {N_IN{`PR_IN_SEL_RST_DEF}}
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic one_way_lock_fuse_in,
  input wire logic sleep_in,
  input wire logic [N_PIN-1:0] pin_level_in,
  input wire logic [N_PIN-1:0] schmitt_level_in,
  input wire logic [N_PIN-1:0] input_level_select_in,
  input wire logic [N_PIN-1:0] analog_select_bit_in,
  input wire logic [N_PIN-1:0] pin_direction_control_in,
  input wire logic [N_PIN-1:0] port_latch_in,
  input wire logic [31:0] periph_out_in,
  input wire logic [31:0] periph_oe_b_in,
  input wire logic [31:0] periph_owns_drive_in,
  input wire logic in_sel_wr_in,
  input wire logic [$clog2(N_IN)-1:0] in_sel_idx_in,
  input wire logic out_sel_wr_in,
  input wire logic [$clog2(N_PIN)-1:0] out_sel_idx_in,
  input wire logic [7:0] sel_wdata_in,
  input wire logic lock_wr_in,
  input wire logic lock_bit_op_in,
  input wire logic lock_bit_val_in,
  input wire logic [7:0] lock_wdata_in,
  output logic selection_lock_flag_out,
  output logic [N_IN-1:0] periph_in_out,
  output logic [N_PIN-1:0] pin_out_out,
  output logic [N_PIN-1:0] pin_oe_b_out,
  output logic [N_PIN-1:0] port_read_out,
  output logic [N_IN*8-1:0] in_sel_rd_out,
  output logic [N_PIN*8-1:0] out_sel_rd_out
);
  // ------------------------------------------------------------
  // Pin synchronisers (pins are asynchronous)
  // ------------------------------------------------------------
  logic [N_PIN-1:0] pin_s1_ff;
  logic [N_PIN-1:0] pin_s2_ff;
  logic [N_PIN-1:0] st_s1_ff;
  logic [N_PIN-1:0] st_s2_ff;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      st_s1_ff <= '0;
      st_s2_ff <= '0;
    end else if (ce_in) begin
      pin_s1_ff <= pin_level_in;
      pin_s2_ff <= pin_s1_ff;
      st_s1_ff <= schmitt_level_in;
      st_s2_ff <= st_s1_ff;
    end
  end
  // level select per pin; analog select kills digital buffer
  // Bitwise pick, so one pin's level choice never moves its neighbours
  wire [N_PIN-1:0] st_pick = input_level_select_in & st_s2_ff;
  wire [N_PIN-1:0] ttl_pick = ~input_level_select_in & pin_s2_ff;
  wire [N_PIN-1:0] dig_level = (st_pick | ttl_pick) & ~analog_select_bit_in;
  // port read is the synchronised digital level, the same one the input selectors see
  assign port_read_out = dig_level;
  // ------------------------------------------------------------
  // Lock unit
  // ------------------------------------------------------------
  pr_lock_if lk_bus ();
  assign lk_bus.wr = lock_wr_in;
  assign lk_bus.bit_op = lock_bit_op_in;
  assign lk_bus.bit_val = lock_bit_val_in;
  assign lk_bus.data = lock_wdata_in;
  // rst_b_in is the power-on reset; other resets never reach this block
  pr_lock u_lock (
    .clk_in(mclk_in),
    .por_b_in(rst_b_in),
    .ce_in(ce_in),
    .one_way_in(one_way_lock_fuse_in),
    .lk(lk_bus)
  );
  assign selection_lock_flag_out = lk_bus.locked;
  // writes gated by lock; sleep does not touch selectors
  wire in_wr_ok = in_sel_wr_in && !lk_bus.locked;
  wire out_wr_ok = out_sel_wr_in && !lk_bus.locked;
  // ------------------------------------------------------------
  // Input selectors, one per peripheral input
  // ------------------------------------------------------------
  localparam int IDX_IN_W = $clog2(N_IN);
  localparam int IDX_PIN_W = $clog2(N_PIN);
  pr_pkg::pr_sel_type in_sel_ff [N_IN];
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in
      always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          in_sel_ff[gi] <= IN_RST[gi*5 +: 5];
        // only the input write strobe touches input selectors
        end else if (ce_in && in_wr_ok && in_sel_idx_in == IDX_IN_W'(gi)) begin
          in_sel_ff[gi] <= sel_wdata_in[4:0];
        end
      end
      // port in 4:3, pin in 2:0 (flat index is the code)
      assign periph_in_out[gi] = dig_level[in_sel_ff[gi]];
      assign in_sel_rd_out[gi*8 +: 8] = {3'h0, in_sel_ff[gi]};
    end
  endgenerate
  // ------------------------------------------------------------
  // Output selectors, one per pin
  // ------------------------------------------------------------
  pr_pkg::pr_sel_type out_sel_ff [N_PIN];
  logic [N_PIN-1:0] pin_q_ff;
  logic [N_PIN-1:0] oe_b_ff;
  genvar gp;
  generate
    for (gp = 0; gp < N_PIN; gp++) begin : g_out
      always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          out_sel_ff[gp] <= `PR_OUT_SEL_RST;
        // only the output write strobe touches output selectors
        end else if (ce_in && out_wr_ok && out_sel_idx_in == IDX_PIN_W'(gp)) begin
          out_sel_ff[gp] <= sel_wdata_in[4:0];
        end
      end
      // code zero is port latch; one common code space
      wire zero_sel = (out_sel_ff[gp] == `PR_OUT_SEL_RST);
      wire nxt_pin = zero_sel ? port_latch_in[gp] : periph_out_in[out_sel_ff[gp]];
      // owning peripheral drives enable; otherwise direction bit
      wire owns = !zero_sel && periph_owns_drive_in[out_sel_ff[gp]];
      wire nxt_oe_b = owns ? periph_oe_b_in[out_sel_ff[gp]] : pin_direction_control_in[gp];
      // Registered so pin data never glitches on selector change
      always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          pin_q_ff[gp] <= 1'b0;
          oe_b_ff[gp] <= 1'b1;
        end else if (ce_in) begin
          pin_q_ff[gp] <= nxt_pin;
          oe_b_ff[gp] <= nxt_oe_b;
        end
      end
      assign out_sel_rd_out[gp*8 +: 8] = {3'h0, out_sel_ff[gp]};
    end
  endgenerate
  // analog signals never enter this mux
  assign pin_out_out = pin_q_ff;
  assign pin_oe_b_out = oe_b_ff;
endmodule

// *** verification/pr_router_chk.sv ***
// Assertion checker bound to the peripheral pin router
`timescale 1ns/1ns
module pr_router_chk #(
  parameter int N_IN = 8,
  parameter int N_PIN = 32
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic one_way_lock_fuse_in,
  input wire logic in_sel_wr_in,
  input wire logic [$clog2(N_IN)-1:0] in_sel_idx_in,
  input wire logic out_sel_wr_in,
  input wire logic [$clog2(N_PIN)-1:0] out_sel_idx_in,
  input wire logic [7:0] sel_wdata_in,
  input wire logic lock_wr_in,
  input wire logic lock_bit_op_in,
  input wire logic lock_bit_val_in,
  input wire logic [7:0] lock_wdata_in,
  input wire logic selection_lock_flag_out,
  input wire logic [N_IN*8-1:0] in_sel_rd_out,
  input wire logic [N_PIN*8-1:0] out_sel_rd_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // Key steps; one idle cycle between them, as the bench paces them
  sequence s_k55;
    ce_in && lock_wr_in && !lock_bit_op_in && lock_wdata_in == 8'h55 && !one_way_lock_fuse_in;
  endsequence
  sequence s_kaa;
    ce_in && lock_wr_in && !lock_bit_op_in && lock_wdata_in == 8'hAA;
  endsequence
  sequence s_set;
    ce_in && lock_wr_in && lock_bit_op_in && lock_bit_val_in;
  endsequence
  sequence s_byte;
    ce_in && lock_wr_in && !lock_bit_op_in;
  endsequence
  a_key_sets_flag: assert property (s_k55 ##2 s_kaa ##2 s_set |=> selection_lock_flag_out)
    else $error("key sequence did not lock");
  a_byte_no_flag: assert property (s_byte |=> $stable(selection_lock_flag_out))
    else $error("byte write moved lock flag");
  a_flag_by_bitop: assert property ($changed(selection_lock_flag_out) |->
    $past(ce_in && lock_wr_in && lock_bit_op_in)) else $error("flag moved without bit op");
  a_in_lock_frz: assert property (ce_in && in_sel_wr_in && selection_lock_flag_out
    |=> $stable(in_sel_rd_out)) else $error("locked selector changed");
  a_in_wr_lands: assert property (ce_in && in_sel_wr_in && !selection_lock_flag_out &&
    in_sel_idx_in == 0 |=> in_sel_rd_out[4:0] == $past(sel_wdata_in[4:0]))
    else $error("input selector write lost");
  a_in_no_cross: assert property (ce_in && in_sel_wr_in && !out_sel_wr_in
    |=> $stable(out_sel_rd_out)) else $error("input write changed output selector");
  a_out_wr_lands: assert property (ce_in && out_sel_wr_in && !selection_lock_flag_out &&
    out_sel_idx_in == 22 |=> out_sel_rd_out[180:176] == $past(sel_wdata_in[4:0]))
    else $error("output selector write lost");
  a_upper_zero: assert property (in_sel_rd_out[7:5] == 3'b000)
    else $error("selector upper bits not zero");
endmodule
bind pr_router pr_router_chk #(.N_IN(N_IN), .N_PIN(N_PIN)) pr_router_chk_i (
  .mclk_in, .rst_b_in, .ce_in, .one_way_lock_fuse_in, .in_sel_wr_in, .in_sel_idx_in,
  .out_sel_wr_in, .out_sel_idx_in, .sel_wdata_in, .lock_wr_in, .lock_bit_op_in,
  .lock_bit_val_in, .lock_wdata_in, .selection_lock_flag_out, .in_sel_rd_out, .out_sel_rd_out
);

// *** verification/pr_far_model.sv ***
// Pin world model: driver wins, else the outside level
`timescale 1ns/1ns
module pr_far_model (
  input wire logic [31:0] ext_in,
  input wire logic [31:0] ext_st_in,
  input wire logic [31:0] pin_out_in,
  input wire logic [31:0] pin_oe_b_in,
  output logic [31:0] pin_level_out,
  output logic [31:0] schmitt_level_out
);
  // pad level seen by input buffers
  assign pin_level_out = (pin_oe_b_in & ext_in) | (~pin_oe_b_in & pin_out_in);
  // outside Schmitt view may differ from the TTL view on undriven pins
  assign schmitt_level_out = (pin_oe_b_in & ext_st_in) | (~pin_oe_b_in & pin_out_in);
endmodule

// *** verification/pr_router_tb.sv ***
// Self-checking bench for the peripheral pin router
`timescale 1ns/1ns
module pr_router_tb;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, fuse = 1'b0, slp = 1'b0;
  logic [31:0] ext = '0, ana = '0, dir = '1, pout = '0, poe_b = '1, owns = '0;
  logic [31:0] lvl, st, pin_o, pin_oe_b, prd;
  logic [31:0] ext_st = '0, ils = '0, plat = '0;
  logic iwr = 1'b0, owr = 1'b0, lwr = 1'b0, lop = 1'b0, lval = 1'b0, flag;
  logic [1:0] iidx = '0;
  logic [4:0] oidx = '0;
  logic [7:0] wd = '0, lwd = '0;
  logic [3:0] pin_in;
  logic [31:0] in_rd;
  logic [255:0] out_rd;
  int err_count = 0, tests_run = 0;
  pr_router #(.N_IN(4), .N_OUT(4), .N_PIN(32), .IN_RST(20'h7A217)) pr_router_i (
    .mclk_in(clk), .rst_b_in(rst_b), .ce_in(ce), .one_way_lock_fuse_in(fuse), .sleep_in(slp),
    .pin_level_in(lvl), .schmitt_level_in(st), .input_level_select_in(ils),
    .analog_select_bit_in(ana), .pin_direction_control_in(dir), .port_latch_in(plat),
    .periph_out_in(pout), .periph_oe_b_in(poe_b), .periph_owns_drive_in(owns),
    .in_sel_wr_in(iwr), .in_sel_idx_in(iidx), .out_sel_wr_in(owr), .out_sel_idx_in(oidx),
    .sel_wdata_in(wd), .lock_wr_in(lwr), .lock_bit_op_in(lop), .lock_bit_val_in(lval),
    .lock_wdata_in(lwd), .selection_lock_flag_out(flag), .periph_in_out(pin_in),
    .pin_out_out(pin_o), .pin_oe_b_out(pin_oe_b), .port_read_out(prd),
    .in_sel_rd_out(in_rd), .out_sel_rd_out(out_rd));
  pr_far_model pr_far_model_i (.ext_in(ext), .ext_st_in(ext_st), .pin_out_in(pin_o),
    .pin_oe_b_in(pin_oe_b),
    .pin_level_out(lvl), .schmitt_level_out(st));
  // Kind 0 input sel, 1 output sel, 2 lock write; strobe held one edge
  task automatic op(input int k, input logic [4:0] i, input logic [7:0] d, input logic b,
      input logic v);
    @(posedge clk);
    #1;
    {iidx, oidx, wd, lwd, lop, lval} = {i[1:0], i, d, d, b, v};
    {iwr, owr, lwr} = {k == 0, k == 1, k == 2};
    @(posedge clk);
    #1;
    {iwr, owr, lwr} = 3'b000;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic key(input logic v);
    op(2, 0, 8'h55, 0, 0);
    op(2, 0, 8'hAA, 0, 0);
    op(2, 0, 0, 1, v);
    tick(1);
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  // Watchdog, far beyond the hundred or so cycles used
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  initial begin
    tick(4);
    rst_b = 1'b1;
    check("in_rst", in_rd, 32'h0F08_1017);
    check("out_rst", out_rd[31:0], 32'h0);
    op(0, 0, 8'h17, 0, 0);
    op(0, 1, 8'h17, 0, 0);
    ext[23] = 1'b1;
    tick(4);
    check("fanout", pin_in[1:0], 2'b11);
    check("port_rd", prd[23], 1'b1);
    ana[23] = 1'b1;
    tick(4);
    check("analog", pin_in[1:0], 2'b00);
    ana[23] = 1'b0;
    op(1, 22, 8'h09, 0, 0);
    pout[9] = 1'b1;
    dir[22] = 1'b0;
    tick(3);
    check("tx_pin", {pin_oe_b[22], pin_o[22]}, 2'b01);
    dir[22] = 1'b1;
    tick(3);
    check("dir_ctl", pin_oe_b[22], 1'b1);
    {owns[9], poe_b[9]} = 2'b10;
    op(0, 2, 8'h16, 0, 0);
    tick(4);
    check("override", {pin_oe_b[22], pin_in[2]}, 2'b01);
    key(1);
    check("locked", flag, 1'b1);
    op(0, 0, 8'h01, 0, 0);
    op(1, 22, 8'h00, 0, 0);
    tick(1);
    check("frozen", {in_rd[7:0], out_rd[183:176]}, 16'h1709);
    op(2, 0, 8'h55, 0, 0);
    op(2, 0, 8'hAA, 0, 0);
    op(2, 0, 8'h00, 0, 0);
    tick(1);
    check("byte_wr", flag, 1'b1);
    op(2, 0, 0, 1, 0);
    tick(1);
    check("abandon", flag, 1'b1);
    op(2, 0, 8'h55, 0, 0);
    op(2, 0, 8'h00, 0, 0);
    key(0);
    check("unlock", flag, 1'b0);
    slp = 1'b1;
    tick(2);
    slp = 1'b0;
    check("sleep", in_rd, 32'h0F16_1717);
    ext_st[15] = 1'b1;
    ils[15] = 1'b1;
    tick(3);
    check("st_view", {prd[15], pin_in[3], pin_in[0]}, 3'b111);
    ils[15] = 1'b0;
    tick(1);
    check("ttl_view", pin_in[3], 1'b0);
    plat[5] = 1'b1;
    dir[5] = 1'b0;
    tick(2);
    check("latch", {pin_oe_b[5], pin_o[5]}, 2'b01);
    ce = 1'b0;
    op(0, 3, 8'h01, 0, 0);
    ce = 1'b1;
    tick(1);
    check("ce_hold", in_rd[31:24], 8'h0F);
    fuse = 1'b1;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    check("por", in_rd, 32'h0F08_1017);
    key(0);
    key(1);
    key(0);
    check("one_way", flag, 1'b1);
    give_verdict;
  end
endmodule
